// >>> verilog/lsq_pkg.sv
// Shared constants, types and helpers for the link status query link
package lsq_pkg;
  // ************************************************************
  // Packet type codes and header layout
  // ************************************************************
  localparam logic [7:0] LSQ_TYPE_QUERY = 8'h0A;
  localparam logic [7:0] LSQ_TYPE_RESP  = 8'h8A;
  localparam logic [7:0] LSQ_HDR_REV    = 8'h01;
  localparam logic [7:0] LSQ_MC_ID      = 8'h00;
  localparam logic [5:0] LSQ_B_IID      = 6'h03;
  localparam logic [5:0] LSQ_B_TYPE     = 6'h04;
  localparam logic [5:0] LSQ_B_CHAN     = 6'h05;
  localparam logic [5:0] LSQ_HDR_END    = 6'h0F;
  localparam logic [5:0] LSQ_Q_CSUM     = 6'h10;
  localparam logic [5:0] LSQ_R_CODE     = 6'h10;
  localparam logic [5:0] LSQ_R_LINK     = 6'h14;
  localparam logic [5:0] LSQ_R_OTHER    = 6'h18;
  localparam logic [5:0] LSQ_R_VEND     = 6'h1C;
  localparam logic [5:0] LSQ_R_CSUM     = 6'h20;
  localparam logic [5:0] LSQ_R_PAD      = 6'h24;
  localparam logic [5:0] LSQ_LAST       = 6'h2D;
  localparam logic [5:0] LSQ_CNT_MAX    = 6'h3F;
  // ************************************************************
  // Link status word bit positions
  // ************************************************************
  localparam int LSQ_LS_UP    = 0;
  localparam int LSQ_LS_SPD   = 1;
  localparam int LSQ_LS_AN_EN = 5;
  localparam int LSQ_LS_AN_OK = 6;
  localparam int LSQ_LS_PD    = 7;
  // ************************************************************
  // Speed and duplex codes
  // ************************************************************
  localparam logic [3:0] LSQ_SPD_NONE   = 4'h0;
  localparam logic [3:0] LSQ_SPD_10HD   = 4'h1;
  localparam logic [3:0] LSQ_SPD_10FD   = 4'h2;
  localparam logic [3:0] LSQ_SPD_100HD  = 4'h3;
  localparam logic [3:0] LSQ_SPD_100FD  = 4'h5;
  localparam logic [3:0] LSQ_SPD_1GFD   = 4'h6;
  localparam logic [3:0] LSQ_SPD_1GHD   = 4'h7;
  localparam logic [3:0] LSQ_SPD_10G    = 4'h8;
  localparam logic [3:0] LSQ_SPD_20G    = 4'h9;
  localparam logic [3:0] LSQ_SPD_25G    = 4'hA;
  localparam logic [3:0] LSQ_SPD_40G    = 4'hB;
  localparam logic [3:0] LSQ_SPD_50G    = 4'hC;
  localparam logic [3:0] LSQ_SPD_2G5    = 4'hE;
  localparam logic [3:0] LSQ_SPD_ENH    = 4'hF;
  // ************************************************************
  // Controller register map
  // ************************************************************
  localparam logic [11:0] LSQ_A_CTRL = 12'h000;
  localparam logic [11:0] LSQ_A_STAT = 12'h004;
  localparam logic [11:0] LSQ_A_LINK = 12'h008;
  localparam logic [11:0] LSQ_A_VEND = 12'h00C;
  localparam logic [11:0] LSQ_A_RESP = 12'h010;
  localparam int LSQ_C_START = 0;
  localparam int LSQ_C_CHAN  = 8;
  localparam int LSQ_C_IID   = 16;
  localparam int LSQ_S_BUSY  = 0;
  localparam int LSQ_S_DONE  = 1;
  localparam int LSQ_S_ERR   = 2;
  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    MODE_10_HD   = 4'h0,
    MODE_10_FD   = 4'h1,
    MODE_100_HD  = 4'h2,
    MODE_100_FD  = 4'h3,
    MODE_1G_HD   = 4'h4,
    MODE_1G_FD   = 4'h5,
    MODE_2G5     = 4'h6,
    MODE_10G     = 4'h7,
    MODE_20G     = 4'h8,
    MODE_25G     = 4'h9,
    MODE_40G     = 4'hA,
    MODE_50G     = 4'hB,
    MODE_ENHANCE = 4'hC
  } lsq_mode_e;
  typedef enum logic [1:0] {
    DS_RX = 2'b00,
    DS_TX = 2'b01
  } lsq_dst_e;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_TX   = 2'b01,
    HS_RX   = 2'b10
  } lsq_hst_e;
  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] lsq_csum_add(input logic [31:0] s, input logic [15:0] w);
    return s + {16'h0000, w};
  endfunction
  function automatic logic [7:0] lsq_word_byte(input logic [31:0] w, input logic [1:0] k);
    case (k)
      2'h0:    return w[31:24];
      2'h1:    return w[23:16];
      2'h2:    return w[15:8];
      default: return w[7:0];
    endcase
  endfunction
endpackage

// >>> verilog/lsq_link_if.sv
// Byte stream link between management controller and channel
`timescale 1ns/1ps
interface lsq_link_if;
  logic       q_valid;
  logic [7:0] q_data;
  logic       q_last;
  logic       q_ready;
  logic       r_valid;
  logic [7:0] r_data;
  logic       r_last;
  logic       r_ready;
  modport dev (input q_valid, q_data, q_last, r_ready, output q_ready, r_valid, r_data, r_last);
  modport mc  (output q_valid, q_data, q_last, r_ready, input q_ready, r_valid, r_data, r_last);
endinterface

// >>> verilog/lsq_status_enc.sv
// Link status word encoder for the channel
`timescale 1ns/1ps
module lsq_status_enc
  import lsq_pkg::*;
#(
  parameter bit AN_SUPPORTED = 1'b1,
  parameter bit V11_CODES    = 1'b1
) (
  input  wire logic        link_up,
  input  wire logic        lpi_active,
  input  wire logic        an_enabled,
  input  wire logic        an_complete,
  input  wire logic        serdes_mode,
  input  wire logic        parallel_detect,
  input  wire logic        mode_found,
  input  wire lsq_mode_e   highest_common_mode,
  output logic      [31:0] status_word
);
  logic       an_on;
  logic       an_ok;
  logic [3:0] spd;

  // ************************************************************
  // Mode to code mapping
  // ************************************************************
  always_comb begin
    an_on = AN_SUPPORTED & an_enabled; // [RL13] [RL15]
    an_ok = an_on & an_complete; // [RL14] [RL15]
    case (highest_common_mode)
      MODE_10_HD:   spd = LSQ_SPD_10HD; // [RL8]
      MODE_10_FD:   spd = LSQ_SPD_10FD; // [RL8]
      MODE_100_HD:  spd = LSQ_SPD_100HD; // [RL9]
      MODE_100_FD:  spd = LSQ_SPD_100FD; // [RL8]
      MODE_1G_HD:   spd = LSQ_SPD_1GHD; // [RL8]
      MODE_1G_FD:   spd = LSQ_SPD_1GFD; // [RL8]
      MODE_10G:     spd = LSQ_SPD_10G; // [RL8]
      // Older revision lacks these codes, so report nearest listed one
      MODE_2G5:     spd = V11_CODES ? LSQ_SPD_2G5 : LSQ_SPD_1GFD; // [RL10] [RL12]
      MODE_20G:     spd = V11_CODES ? LSQ_SPD_20G : LSQ_SPD_10G; // [RL10] [RL12]
      MODE_25G:     spd = V11_CODES ? LSQ_SPD_25G : LSQ_SPD_10G; // [RL10] [RL12]
      MODE_40G:     spd = V11_CODES ? LSQ_SPD_40G : LSQ_SPD_10G; // [RL10] [RL12]
      MODE_50G:     spd = V11_CODES ? LSQ_SPD_50G : LSQ_SPD_10G; // [RL10] [RL12]
      MODE_ENHANCE: spd = V11_CODES ? LSQ_SPD_ENH : LSQ_SPD_10G; // [RL11]
      default:      spd = LSQ_SPD_NONE;
    endcase
    if ((an_on && !an_ok) || serdes_mode || !mode_found) begin
      spd = LSQ_SPD_NONE; // [RL7]
    end
    status_word                  = 32'h0000_0000;
    // Low power idle keeps the link reported as up
    status_word[LSQ_LS_UP]       = link_up | lpi_active; // [RL6] [RL15]
    status_word[LSQ_LS_SPD+:4]   = spd; // [RL7]
    status_word[LSQ_LS_AN_EN]    = an_on; // [RL13]
    status_word[LSQ_LS_AN_OK]    = an_ok; // [RL14]
    status_word[LSQ_LS_PD]       = parallel_detect & an_ok; // [RL16]
  end
endmodule

// >>> verilog/lsq_responder.sv
// Channel end: answers link status queries on the byte link
// Operation
// RL1 - Query identified by type code 0x0A
// RL2 - Query: header, checksum, then padding
// RL3 - Response carries type code 0x8A
// RL4 - Answer unless checksum or identifier mismatch
// RL5 - Response fields at fixed byte offsets
// RL6 - Bit 0 link up; idle counts up
// RL7 - Code zero when negotiation incomplete or none
// RL8 - Listed speed codes one to eight
// RL9 - 100 half duplex reported as 0x3
// RL10 - Optional higher speeds, version dependent
// RL11 - Code 0xF points to enhanced field
// RL12 - Unlisted speed reported as closest
// RL13 - Bit 5 negotiation enabled
// RL14 - Bit 6 negotiation complete
// RL15 - Mandatory flags always provided
// RL16 - Bit 7 parallel detection used
// RL17 - Status bits from one snapshot
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
module lsq_responder
  import lsq_pkg::*;
#(
  parameter bit AN_SUPPORTED = 1'b1,
  parameter bit V11_CODES    = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  lsq_link_if.dev          lnk,
  input  wire logic [7:0]  channel_id,
  input  wire logic        link_up,
  input  wire logic        lpi_active,
  input  wire logic        an_enabled,
  input  wire logic        an_complete,
  input  wire logic        serdes_mode,
  input  wire logic        parallel_detect,
  input  wire logic        mode_found,
  input  wire lsq_mode_e   highest_common_mode,
  input  wire logic [31:0] vendor_status,
  output logic             served,
  output logic             dropped
);
  lsq_dst_e    state;
  logic [7:0]  hdr [0:15];
  logic [5:0]  rx_cnt;
  logic [7:0]  rx_hi;
  logic [31:0] rx_sum;
  logic [31:0] rx_csum;
  logic [5:0]  tx_cnt;
  logic [7:0]  tx_hi;
  logic [31:0] tx_sum;
  logic [31:0] snap_ls;
  logic [31:0] snap_vend;
  logic [31:0] enc_word;
  logic [7:0]  r_data_q;
  logic        rx_hs;
  logic        tx_hs;
  logic        accept;
  logic [5:0]  next_idx;
  logic [31:0] next_sum;
  logic [31:0] tx_csum;
  logic [7:0]  next_byte;

  // ************************************************************
  // Status encoder
  // ************************************************************
  lsq_status_enc #(
    .AN_SUPPORTED (AN_SUPPORTED),
    .V11_CODES    (V11_CODES)
  ) u_enc (
    .link_up             (link_up),
    .lpi_active          (lpi_active),
    .an_enabled          (an_enabled),
    .an_complete         (an_complete),
    .serdes_mode         (serdes_mode),
    .parallel_detect     (parallel_detect),
    .mode_found          (mode_found),
    .highest_common_mode (highest_common_mode),
    .status_word         (enc_word)
  );

  // ************************************************************
  // Handshakes and query check
  // ************************************************************
  assign lnk.q_ready = (state == DS_RX);
  assign lnk.r_valid = (state == DS_TX);
  assign lnk.r_last  = (state == DS_TX) && (tx_cnt == LSQ_LAST);
  assign lnk.r_data  = r_data_q;
  assign rx_hs       = lnk.q_valid && lnk.q_ready;
  assign tx_hs       = lnk.r_valid && lnk.r_ready;

  // Length, type, channel and checksum must all agree
  assign accept = rx_hs && lnk.q_last && (rx_cnt == LSQ_LAST) // [RL2]
                  && (hdr[LSQ_B_TYPE[3:0]] == LSQ_TYPE_QUERY) // [RL1]
                  && (hdr[LSQ_B_CHAN[3:0]] == channel_id) // [RL4]
                  && ((rx_sum + rx_csum) == 32'h0000_0000); // [RL4]

  // ************************************************************
  // Receive side
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt <= 6'h00;
    end else if (rx_hs) begin
      if (lnk.q_last) begin
        rx_cnt <= 6'h00;
      end else if (rx_cnt != LSQ_CNT_MAX) begin
        rx_cnt <= rx_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        hdr[i] <= 8'h00;
      end
    end else if (rx_hs && rx_cnt <= LSQ_HDR_END) begin
      hdr[rx_cnt[3:0]] <= lnk.q_data; // [RL2]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_hi   <= 8'h00;
      rx_sum  <= 32'h0000_0000;
      rx_csum <= 32'h0000_0000;
    end else if (rx_hs) begin
      rx_hi <= lnk.q_data;
      if (lnk.q_last) begin
        rx_sum <= 32'h0000_0000;
      end else if (rx_cnt <= LSQ_HDR_END && rx_cnt[0]) begin
        rx_sum <= lsq_csum_add(rx_sum, {rx_hi, lnk.q_data}); // [RL4]
      end
      if (rx_cnt >= LSQ_Q_CSUM && rx_cnt < LSQ_Q_CSUM + 6'h04) begin
        rx_csum <= {rx_csum[23:0], lnk.q_data}; // [RL2]
      end
    end
  end

  // ************************************************************
  // Control state
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DS_RX;
    end else begin
      case (state)
        DS_RX: begin
          if (accept) begin
            state <= DS_TX; // [RL4]
          end
        end
        DS_TX: begin
          if (tx_hs && tx_cnt == LSQ_LAST) begin
            state <= DS_RX;
          end
        end
        default: state <= DS_RX;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      served  <= 1'b0;
      dropped <= 1'b0;
    end else begin
      served  <= accept;
      dropped <= rx_hs && lnk.q_last && !accept;
    end
  end

  // One capture per answer, so the speed code and flags never disagree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_ls   <= 32'h0000_0000;
      snap_vend <= 32'h0000_0000;
    end else if (accept) begin
      snap_ls   <= enc_word; // [RL17]
      snap_vend <= vendor_status; // [RL17]
    end
  end

  // ************************************************************
  // Response byte builder
  // ************************************************************
  always_comb begin
    next_idx = tx_cnt + 6'h01;
    next_sum = tx_sum;
    if (tx_cnt < LSQ_R_CSUM && tx_cnt[0]) begin
      next_sum = lsq_csum_add(tx_sum, {tx_hi, r_data_q});
    end
    tx_csum = ~next_sum + 32'h0000_0001;
    if (next_idx <= LSQ_HDR_END) begin
      if (next_idx == LSQ_B_TYPE) begin
        next_byte = LSQ_TYPE_RESP; // [RL3]
      end else begin
        next_byte = hdr[next_idx[3:0]];
      end
    end else if (next_idx < LSQ_R_LINK) begin
      next_byte = 8'h00; // [RL5]
    end else if (next_idx < LSQ_R_OTHER) begin
      next_byte = lsq_word_byte(snap_ls, next_idx[1:0]); // [RL5]
    end else if (next_idx < LSQ_R_VEND) begin
      next_byte = 8'h00; // [RL5]
    end else if (next_idx < LSQ_R_CSUM) begin
      next_byte = lsq_word_byte(snap_vend, next_idx[1:0]); // [RL5]
    end else if (next_idx < LSQ_R_PAD) begin
      next_byte = lsq_word_byte(tx_csum, next_idx[1:0]); // [RL5]
    end else begin
      next_byte = 8'h00; // [RL5]
    end
  end

  // ************************************************************
  // Transmit side
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt   <= 6'h00;
      tx_hi    <= 8'h00;
      tx_sum   <= 32'h0000_0000;
      r_data_q <= 8'h00;
    end else if (accept) begin
      tx_cnt   <= 6'h00;
      tx_sum   <= 32'h0000_0000;
      r_data_q <= hdr[0];
    end else if (tx_hs && tx_cnt != LSQ_LAST) begin
      tx_cnt   <= next_idx;
      tx_hi    <= r_data_q;
      tx_sum   <= next_sum;
      r_data_q <= next_byte;
    end
  end
endmodule

// >>> verilog/lsq_query_master.sv
// Management controller end: issues link status queries under APB control
`timescale 1ns/1ps
module lsq_query_master
  import lsq_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  lsq_link_if.mc           lnk
);
  lsq_hst_e    state;
  logic [7:0]  chan;
  logic [7:0]  iid;
  logic [5:0]  cnt;
  logic [7:0]  q_data_q;
  logic [7:0]  rx_hi;
  logic [31:0] rx_sum;
  logic [7:0]  rx_type;
  logic [7:0]  rx_iid;
  logic [31:0] resp_code;
  logic [31:0] link_word;
  logic [31:0] vend_word;
  logic        done;
  logic        err;
  logic        wr;
  logic        mapped;
  logic        start;
  logic        q_hs;
  logic        r_hs;
  logic        r_end;
  logic        bad;
  logic [31:0] q_csum;
  logic [31:0] rx_csum;
  logic [31:0] fin_sum;
  logic [5:0]  next_idx;
  logic [7:0]  next_byte;

  // ************************************************************
  // APB slave, zero wait states
  // ************************************************************
  assign pready = 1'b1;
  assign wr     = psel && penable && pwrite;
  assign mapped = (paddr == LSQ_A_CTRL) || (paddr == LSQ_A_STAT) || (paddr == LSQ_A_LINK)
                  || (paddr == LSQ_A_VEND) || (paddr == LSQ_A_RESP);
  assign pslverr = psel && penable && !mapped;
  // Start while busy is ignored rather than queued
  assign start = wr && (paddr == LSQ_A_CTRL) && pwdata[LSQ_C_START] && (state == HS_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        LSQ_A_CTRL: prdata <= {8'h00, iid, chan, 8'h00};
        LSQ_A_STAT: prdata <= {29'h0, err, done, state != HS_IDLE};
        LSQ_A_LINK: prdata <= link_word;
        LSQ_A_VEND: prdata <= vend_word;
        LSQ_A_RESP: prdata <= resp_code;
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan <= 8'h00;
      iid  <= 8'h00;
    end else if (start) begin
      chan <= pwdata[LSQ_C_CHAN+:8];
      iid  <= pwdata[LSQ_C_IID+:8];
    end
  end

  // ************************************************************
  // Query stream
  // ************************************************************
  assign q_hs        = lnk.q_valid && lnk.q_ready;
  assign r_hs        = lnk.r_valid && lnk.r_ready;
  assign r_end       = r_hs && lnk.r_last;
  assign lnk.q_valid = (state == HS_TX);
  assign lnk.q_last  = (state == HS_TX) && (cnt == LSQ_LAST);
  assign lnk.q_data  = q_data_q;
  assign lnk.r_ready = (state == HS_RX);

  always_comb begin
    q_csum = 32'h0000_0000;
    q_csum = lsq_csum_add(q_csum, {LSQ_MC_ID, LSQ_HDR_REV});
    q_csum = lsq_csum_add(q_csum, {8'h00, iid});
    q_csum = lsq_csum_add(q_csum, {LSQ_TYPE_QUERY, chan});
    q_csum = ~q_csum + 32'h0000_0001;
    next_idx = cnt + 6'h01;
    case (next_idx)
      6'h01:      next_byte = LSQ_HDR_REV;
      LSQ_B_IID:  next_byte = iid;
      LSQ_B_TYPE: next_byte = LSQ_TYPE_QUERY; // [RL1]
      LSQ_B_CHAN: next_byte = chan;
      default:    next_byte = 8'h00; // [RL2]
    endcase
    if (next_idx >= LSQ_Q_CSUM && next_idx < LSQ_Q_CSUM + 6'h04) begin
      next_byte = lsq_word_byte(q_csum, next_idx[1:0]); // [RL2]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= HS_IDLE;
    end else begin
      case (state)
        HS_IDLE: if (start) state <= HS_TX;
        HS_TX:   if (q_hs && cnt == LSQ_LAST) state <= HS_RX;
        HS_RX:   if (r_end) state <= HS_IDLE;
        default: state <= HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt      <= 6'h00;
      q_data_q <= 8'h00;
    end else if (start) begin
      cnt      <= 6'h00;
      q_data_q <= LSQ_MC_ID;
    end else if (q_hs) begin
      cnt      <= (cnt == LSQ_LAST) ? 6'h00 : next_idx;
      q_data_q <= next_byte;
    end else if (r_hs) begin
      cnt <= r_end ? 6'h00 : (cnt == LSQ_CNT_MAX ? cnt : next_idx);
    end
  end

  // ************************************************************
  // Response capture
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_hi     <= 8'h00;
      rx_sum    <= 32'h0000_0000;
      rx_csum   <= 32'h0000_0000;
      rx_type   <= 8'h00;
      rx_iid    <= 8'h00;
      resp_code <= 32'h0000_0000;
      link_word <= 32'h0000_0000;
      vend_word <= 32'h0000_0000;
    end else if (start) begin
      rx_sum <= 32'h0000_0000;
    end else if (r_hs) begin
      rx_hi <= lnk.r_data;
      if (cnt < LSQ_R_CSUM && cnt[0]) rx_sum <= lsq_csum_add(rx_sum, {rx_hi, lnk.r_data});
      // Checksum is a 32-bit word, not two more 16-bit terms
      if (cnt >= LSQ_R_CSUM && cnt < LSQ_R_PAD) rx_csum <= {rx_csum[23:0], lnk.r_data};
      if (cnt == LSQ_B_TYPE) rx_type <= lnk.r_data;
      if (cnt == LSQ_B_IID) rx_iid <= lnk.r_data;
      if (cnt >= LSQ_R_CODE && cnt < LSQ_R_LINK) resp_code <= {resp_code[23:0], lnk.r_data};
      if (cnt >= LSQ_R_LINK && cnt < LSQ_R_OTHER) link_word <= {link_word[23:0], lnk.r_data};
      if (cnt >= LSQ_R_VEND && cnt < LSQ_R_CSUM) vend_word <= {vend_word[23:0], lnk.r_data};
    end
  end

  // Sum of the bytes before the pad must fold to zero, type must be the response code and instance must echo back
  always_comb begin
    fin_sum = rx_sum + rx_csum;
    bad = (cnt != LSQ_LAST) || (rx_type != LSQ_TYPE_RESP) || (rx_iid != iid)
          || (fin_sum != 32'h0000_0000); // [RL3]
  end

  // Completion of a response wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
      err  <= 1'b0;
    end else if (r_end) begin
      done <= 1'b1;
      err  <= bad;
    end else if (wr && paddr == LSQ_A_STAT) begin
      done <= done & ~pwdata[LSQ_S_DONE];
      err  <= err & ~pwdata[LSQ_S_ERR];
    end
  end
endmodule

// >>> testbench/lsq_link_assertions.sv
// Checker for the query byte link between the two ends
`timescale 1ns/1ps
module lsq_link_assertions #(
  parameter logic [7:0] CHAN = 8'h03
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       q_valid,
  input wire logic [7:0] q_data,
  input wire logic       q_last,
  input wire logic       q_ready,
  input wire logic       r_valid,
  input wire logic [7:0] r_data,
  input wire logic       r_last,
  input wire logic       r_ready
);
  logic [5:0] qc;
  logic [5:0] rc;
  logic       q_ok;
  wire        qt = q_valid & q_ready;
  wire        rt = r_valid & r_ready;
  // ****
  // Byte counters, restart after each last byte
  // ****
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qc   <= 6'h00;
      rc   <= 6'h00;
      q_ok <= 1'b0;
    end else begin
      if (qt && qc == 6'h05) q_ok <= (q_data == CHAN);
      if (qt) qc <= q_last ? 6'h00 : qc + 6'h01;
      if (rt) rc <= r_last ? 6'h00 : rc + 6'h01;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_qend;
    qt && q_last;
  endsequence
  sequence s_stat;
    rt && rc == 6'h17;
  endsequence
  chk_query_type: assert property (qt && qc == 6'h04 |-> q_data == 8'h0A)
    else $error("query type byte wrong");
  chk_query_len: assert property (s_qend |-> qc == 6'h2D)
    else $error("query length wrong");
  chk_resp_type: assert property (rt && rc == 6'h04 |-> r_data == 8'h8A)
    else $error("response type byte wrong");
  chk_query_answer: assert property (s_qend ##0 q_ok |=> r_valid && !q_ready && rc == 6'h00)
    else $error("query not answered");
  chk_query_drop: assert property (s_qend ##0 !q_ok |=> !r_valid && q_ready)
    else $error("foreign channel query answered");
  chk_resp_len: assert property (rt && r_last |-> rc == 6'h2D)
    else $error("response length wrong");
  chk_pad_zero: assert property (rt && rc > 6'h23 |-> r_data == 8'h00)
    else $error("response pad not zero");
  chk_code_zero: assert property (s_stat ##0 r_data[5] && !r_data[6] |-> !r_data[4:1])
    else $error("speed code set while negotiating");
  chk_an_order: assert property (s_stat ##0 r_data[6] |-> r_data[5])
    else $error("complete flag without enable flag");
  chk_pd_flag: assert property (s_stat ##0 r_data[7] |-> r_data[6])
    else $error("parallel flag without completion");
endmodule

// >>> testbench/test_link_status_query_responder.sv
// Testbench driving both ends of the link status query pair
`timescale 1ns/1ps
module test_link_status_query_responder;
  import lsq_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, vend;
  logic        up, lpi, an_en, an_ok, serdes, pd, found, served, dropped;
  lsq_mode_e   mode;
  int          err_count, compares;
  logic [3:0]  tbl [13] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h6, 4'hE, 4'h8, 4'h9, 4'hA,
                            4'hB, 4'hC, 4'hF};
  lsq_link_if lnk ();
  lsq_query_master lsq_query_master_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(lnk));
  lsq_responder lsq_responder_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk),
    .channel_id(8'h03), .link_up(up), .lpi_active(lpi), .an_enabled(an_en),
    .an_complete(an_ok), .serdes_mode(serdes), .parallel_detect(pd), .mode_found(found),
    .highest_common_mode(mode), .vendor_status(vend), .served(served), .dropped(dropped));
  lsq_link_assertions lsq_link_assertions_inst (.pclk(pclk), .presetn(presetn),
    .q_valid(lnk.q_valid), .q_data(lnk.q_data), .q_last(lnk.q_last), .q_ready(lnk.q_ready),
    .r_valid(lnk.r_valid), .r_data(lnk.r_data), .r_last(lnk.r_last), .r_ready(lnk.r_ready));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait, pready is only trusted at the sampling edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_count++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] exp_word();
    logic e6;
    logic [3:0] c;
    e6 = an_en & an_ok;
    c = ((an_en && !e6) || serdes || !found) ? 4'h0 : tbl[mode];
    return {24'h0, pd & e6, e6, an_en, c, up | lpi};
  endfunction
  task automatic set(input logic [6:0] f, input int m);
    {up, lpi, an_en, an_ok, serdes, pd, found} <= f;
    mode <= lsq_mode_e'(m);
    vend <= {16'hA5C3, 9'h000, f};
    @(posedge pclk);
  endtask
  task automatic query();
    logic [31:0] r;
    logic e;
    int n;
    apb(1'b1, LSQ_A_STAT, 32'h6, r, e);
    apb(1'b1, LSQ_A_CTRL, 32'h0005_0301, r, e);
    n = 0;
    do begin
      apb(1'b0, LSQ_A_STAT, 32'h0, r, e);
      n++;
    end while (r[1] !== 1'b1 && n < 100);
    chk("status", 32'h2, r & 32'h7);
    if (r[1] !== 1'b1) end_sim();
    apb(1'b0, LSQ_A_LINK, 32'h0, r, e);
    chk("link word", exp_word(), r);
    apb(1'b0, LSQ_A_VEND, 32'h0, r, e);
    chk("vendor", vend, r);
    apb(1'b0, LSQ_A_RESP, 32'h0, r, e);
    chk("response code", 32'h0, r);
  endtask
  task automatic t_codes;
    for (int i = 0; i < 13; i++) begin
      set(7'b1011001, i);
      query();
    end
    $display("t_codes done");
  endtask
  task automatic t_flags;
    logic [6:0] f [7] = '{7'h39, 7'h01, 7'h51, 7'h5D, 7'h58, 7'h5B, 7'h4B};
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 7; i++) begin
      set(f[i], 5);
      query();
    end
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    $display("t_flags done");
  endtask
  // Foreign channel is dropped, master stays busy until reset
  task automatic t_reject;
    logic [31:0] r;
    logic e;
    int n;
    apb(1'b1, LSQ_A_STAT, 32'h6, r, e);
    apb(1'b1, LSQ_A_CTRL, 32'h0005_0401, r, e);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (dropped !== 1'b1 && n < 200);
    chk("dropped", 32'h1, {31'h0, dropped});
    chk("served", 32'h0, {31'h0, served});
    if (dropped !== 1'b1) end_sim();
    @(posedge pclk);
    apb(1'b0, LSQ_A_STAT, 32'h0, r, e);
    chk("busy", 32'h1, r & 32'h7);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    query();
    $display("t_reject done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {up, lpi, an_en, an_ok, serdes, pd, found, vend} = '0;
    mode = MODE_10_HD;
    err_count = 0;
    compares = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_codes();
    t_flags();
    t_reject();
    end_sim();
  end
endmodule
